// [rtl/sto_error_supervisor.sv]
`timescale 1ns/1ps
// Function
// [R1] Any detected malfunction forces safe torque-off
// [R2] Transient fault latches shutdown until power cycle
// [R3] Integrity fault latches permanent global fault
// [R4] Software fault shuts module; acknowledge clears
// [R5] Axis command low forces torque-off
// [R6] Input image seven bytes, two usage
// [R7] Output image seven bytes, two usage
// [R8] Axis A bit 0.0, axis B 1.0; the output image carries axis B at bit 0.1
// [R9] Report per-axis torque-off state, true enabled
// [R10] One switch-off path per axis, with feedback
// [R11] Sixteen-bit safety address, defaults to one
// [R12] At most 8 connections, 12 CRCs
// [R13] At most 24 safe bytes per connection
// [R14] Standard data limited 54 in, 62 out
// [R15] Readable unique serial number
// [R16] Report most severe state; torque-off held
module sto_error_supervisor
    import sto_pkg::*;
#(
    parameter logic [31:0] SERIAL_NUMBER = sto_pkg::SERIAL_DEFAULT
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Self-diagnosis fault inputs (asynchronous)
    input wire sto_pkg::sto_faults_t faultIn,
    // Safety process image from controller
    input wire logic [8*sto_pkg::IMG_IN_BYTES-1:0] imageIn,
    // Torque-off and status outputs
    output sto_pkg::sto_axes_t axisSwitchOffPath,
    output sto_pkg::sto_axes_t driveTorqueOffFeedback,
    output logic [8*sto_pkg::IMG_OUT_BYTES-1:0] imageOut,
    output sto_pkg::sto_state_t errorState,
    output logic irq
);
    import sto_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        sto_faults_t sync1;
        sto_faults_t sync2;
        logic [8*IMG_IN_BYTES-1:0] imgS1;
        logic [8*IMG_IN_BYTES-1:0] imgS2;
        logic gshut;
        logic gfault;
        logic mshut;
        sto_state_t state;
        sto_axes_t path;
        sto_axes_t feedback;
        logic [8*IMG_OUT_BYTES-1:0] img;
        logic [15:0] safeAddr;
        logic [3:0] connCount;
        logic [3:0] crcCount;
        logic [4:0] safeBytes;
        logic [5:0] stdIn;
        logic [5:0] stdOut;
        logic [IRQ_W-1:0] irqStat;
        logic [IRQ_W-1:0] irqMask;
        logic irq;
        logic dPend;
        logic dWrite;
        logic [7:0] dAddr;
        logic [31:0] rdata;
    } sto_regs_t;

    sto_regs_t r;
    sto_regs_t next_r;

    logic addrPhase;
    logic cmdA;
    logic cmdB;
    logic ack;
    logic limitErr;
    logic [IRQ_W-1:0] events;
    logic [4:0] reqSafe;
    logic [3:0] reqConn;
    logic [3:0] reqCrc;
    logic [5:0] reqIn;
    logic [5:0] reqOut;

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        next_r = r;
        addrPhase = hsel && hready && htrans[1];
        // Two-flop synchronisers for pin inputs
        next_r.sync1 = faultIn;
        next_r.sync2 = r.sync1;
        next_r.imgS1 = imageIn;
        next_r.imgS2 = r.imgS1;
        // Axis commands at bytes 0 and 1, bit 0
        cmdA = r.imgS2[8*AXIS_A_BYTE]; // R8
        cmdB = r.imgS2[8*AXIS_B_BYTE]; // R8
        ack = r.dPend && r.dWrite && (r.dAddr == OFS_CTRL) && hwdata[CTRL_ACK_BIT];

        // Latching error states
        if (r.sync2.transientFault) begin
            next_r.gshut = 1'b1; // R2
        end
        if (r.sync2.integrityFault) begin
            next_r.gfault = 1'b1; // R3
        end
        if (r.sync2.softwareFault ||
                (r.dPend && r.dWrite && r.dAddr == OFS_CTRL && hwdata[CTRL_SW_ERR_BIT])) begin
            next_r.mshut = 1'b1; // R4
        end else if (ack) begin
            next_r.mshut = 1'b0; // R4
        end

        // Most severe state wins
        if (r.gfault) begin
            next_r.state = ST_GFAULT; // R16
        end else if (r.gshut) begin
            next_r.state = ST_GSHUT; // R16
        end else if (r.mshut) begin
            next_r.state = ST_MSHUT; // R16
        end else begin
            next_r.state = ST_RUN;
        end

        // Switch-off paths, high means motion allowed
        next_r.path.axisA = cmdA && (r.state == ST_RUN); // R1 R5 R10
        next_r.path.axisB = cmdB && (r.state == ST_RUN); // R1 R5 R10
        next_r.feedback = r.path; // R10
        next_r.img = '0;
        next_r.img[8*AXIS_A_BYTE] = r.path.axisA; // R7 R9
        next_r.img[8*AXIS_A_BYTE+1] = r.path.axisB; // R9

        // Capacity checks on configuration writes
        reqConn = hwdata[3:0];
        reqCrc = hwdata[7:4];
        reqSafe = hwdata[12:8];
        reqIn = hwdata[21:16];
        reqOut = hwdata[29:24];
        limitErr = 1'b0;

        // Interrupt events
        events = '0;
        events[IRQ_GSHUT_BIT] = r.sync2.transientFault && !r.gshut;
        events[IRQ_GFAULT_BIT] = r.sync2.integrityFault && !r.gfault;
        events[IRQ_MSHUT_BIT] = next_r.mshut && !r.mshut;

        // Bus data phase
        next_r.dPend = addrPhase;
        next_r.dWrite = hwrite;
        next_r.dAddr = haddr[7:0];
        if (r.dPend && r.dWrite) begin
            unique case (r.dAddr)
                OFS_IRQ_STAT: next_r.irqStat = r.irqStat & ~hwdata[IRQ_W-1:0];
                OFS_IRQ_MASK: next_r.irqMask = hwdata[IRQ_W-1:0];
                OFS_SAFE_ADDR: next_r.safeAddr = hwdata[15:0]; // R11
                OFS_CONN: begin
                    // Refuse configurations beyond capacity
                    if (reqConn > 4'(MAX_CONN) || reqCrc > 4'(MAX_CRC) ||
                            reqCrc < reqConn ||
                            reqSafe > 5'(MAX_SAFE_BYTES) ||
                            reqIn > 6'(MAX_STD_IN_BYTES) ||
                            reqOut > 6'(MAX_STD_OUT_BYTES)) begin
                        limitErr = 1'b1; // R12 R13 R14
                    end else begin
                        next_r.connCount = reqConn; // R12
                        next_r.crcCount = reqCrc; // R12
                        next_r.safeBytes = reqSafe; // R13
                        next_r.stdIn = reqIn; // R14
                        next_r.stdOut = reqOut; // R14
                    end
                end
                default: ;
            endcase
        end
        events[IRQ_LIMIT_BIT] = limitErr;
        // Set wins over clear
        next_r.irqStat = next_r.irqStat | events;
        next_r.irq = |(next_r.irqStat & next_r.irqMask);

        // Read data
        next_r.rdata = '0;
        if (addrPhase && !hwrite) begin
            unique case (haddr[7:0])
                OFS_CTRL: next_r.rdata = {31'h0, r.mshut};
                OFS_STATUS: next_r.rdata = {26'h0, r.path, r.state};
                OFS_IRQ_STAT: next_r.rdata = {28'h0, r.irqStat};
                OFS_IRQ_MASK: next_r.rdata = {28'h0, r.irqMask};
                OFS_SAFE_ADDR: next_r.rdata = {16'h0, r.safeAddr};
                OFS_CONN: next_r.rdata = {2'h0, r.stdOut, 2'h0, r.stdIn,
                    3'h0, r.safeBytes, r.crcCount, r.connCount};
                OFS_SERIAL: next_r.rdata = SERIAL_NUMBER; // R15
                OFS_IMG_IN: next_r.rdata = {16'h0, r.imgS2[8*IMG_USAGE_BYTES-1:0]}; // R6
                OFS_IMG_OUT: next_r.rdata = {16'h0, r.img[8*IMG_USAGE_BYTES-1:0]}; // R7
                default: next_r.rdata = '0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (reset) begin
            r <= '0;
            r.state <= ST_RUN;
            r.safeAddr <= SAFE_ADDR_RST; // R11
            r.mshut <= 1'b0;
        end else begin
            r <= next_r;
        end
    end

    // Outputs
    assign hrdata = r.rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign axisSwitchOffPath = r.path;
    assign driveTorqueOffFeedback = r.feedback;
    assign imageOut = r.img;
    assign errorState = r.state;
    assign irq = r.irq;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_fault_safe;
        @(posedge core_clk) disable iff (reset)
        (r.state != ST_RUN) |=> !r.path.axisA && !r.path.axisB;
    endproperty
    a_fault_safe: assert property (p_fault_safe) else $error("torque not off"); // R1

    property p_gshut_sticky;
        @(posedge core_clk) disable iff (reset)
        r.gshut |=> r.gshut;
    endproperty
    a_gshut_sticky: assert property (p_gshut_sticky) else $error("shutdown lost"); // R2

    property p_gfault_state;
        @(posedge core_clk) disable iff (reset)
        r.gfault |=> (r.state == ST_GFAULT)[*3];
    endproperty
    a_gfault_state: assert property (p_gfault_state) else $error("fault state wrong"); // R3

    property p_ack_clear;
        @(posedge core_clk) disable iff (reset)
        (ack && !r.sync2.softwareFault && !hwdata[CTRL_SW_ERR_BIT]) |=> !r.mshut;
    endproperty
    a_ack_clear: assert property (p_ack_clear) else $error("ack ignored"); // R4

    property p_cmd_low;
        @(posedge core_clk) disable iff (reset)
        !cmdA |=> !r.path.axisA;
    endproperty
    a_cmd_low: assert property (p_cmd_low) else $error("axis a not off"); // R5

    property p_feedback;
        @(posedge core_clk) disable iff (reset)
        ##1 (r.feedback == $past(r.path));
    endproperty
    a_feedback: assert property (p_feedback) else $error("feedback mismatch"); // R10

    property p_report;
        @(posedge core_clk) disable iff (reset)
        ##1 (r.img[8*AXIS_A_BYTE] == $past(r.path.axisA));
    endproperty
    a_report: assert property (p_report) else $error("report mismatch"); // R9

    property p_limits;
        @(posedge core_clk) disable iff (reset)
        r.connCount <= 4'(MAX_CONN) && r.crcCount <= 4'(MAX_CRC)
            && r.safeBytes <= 5'(MAX_SAFE_BYTES);
    endproperty
    a_limits: assert property (p_limits) else $error("capacity exceeded"); // R12

    property p_severity;
        @(posedge core_clk) disable iff (reset)
        (r.gfault && r.gshut) |=> (r.state == ST_GFAULT);
    endproperty
    a_severity: assert property (p_severity) else $error("severity order"); // R16

    property p_trans_latch;
        @(posedge core_clk) disable iff (reset)
        r.sync2.transientFault |=> r.gshut;
    endproperty
    a_trans_latch: assert property (p_trans_latch) else $error("shutdown not latched"); // R2

    property p_gfault_sticky;
        @(posedge core_clk) disable iff (reset)
        r.gfault |=> r.gfault;
    endproperty
    a_gfault_sticky: assert property (p_gfault_sticky) else $error("fault lost"); // R3

    property p_mshut_set;
        @(posedge core_clk) disable iff (reset)
        r.sync2.softwareFault |=> r.mshut;
    endproperty
    a_mshut_set: assert property (p_mshut_set) else $error("module shutdown missed"); // R4

    property p_cmd_low_b;
        @(posedge core_clk) disable iff (reset)
        !cmdB |=> !r.path.axisB;
    endproperty
    a_cmd_low_b: assert property (p_cmd_low_b) else $error("axis b not off"); // R5

    property p_report_b;
        @(posedge core_clk) disable iff (reset)
        ##1 (r.img[8*AXIS_A_BYTE+1] == $past(r.path.axisB));
    endproperty
    a_report_b: assert property (p_report_b) else $error("report b mismatch"); // R9

    property p_image_pad;
        @(posedge core_clk) disable iff (reset)
        r.img[8*IMG_OUT_BYTES-1:2] == '0;
    endproperty
    a_image_pad: assert property (p_image_pad) else $error("image padding set"); // R7

    property p_gshut_state;
        @(posedge core_clk) disable iff (reset)
        (r.gshut && !r.gfault) |=> (r.state == ST_GSHUT);
    endproperty
    a_gshut_state: assert property (p_gshut_state) else $error("shutdown state wrong"); // R16

    property p_safe_bytes;
        @(posedge core_clk) disable iff (reset)
        r.safeBytes <= 5'(MAX_SAFE_BYTES);
    endproperty
    a_safe_bytes: assert property (p_safe_bytes) else $error("safe data too long"); // R13

    property p_std_limits;
        @(posedge core_clk) disable iff (reset)
        r.stdIn <= 6'(MAX_STD_IN_BYTES) && r.stdOut <= 6'(MAX_STD_OUT_BYTES);
    endproperty
    a_std_limits: assert property (p_std_limits) else $error("standard data too long"); // R14
endmodule : sto_error_supervisor

// [rtl/sto_pkg.sv]
package sto_pkg;
    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h0c;
    localparam logic [7:0] OFS_SAFE_ADDR = 8'h10;
    localparam logic [7:0] OFS_CONN = 8'h14;
    localparam logic [7:0] OFS_SERIAL = 8'h18;
    localparam logic [7:0] OFS_IMG_IN = 8'h1c;
    localparam logic [7:0] OFS_IMG_OUT = 8'h20;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTRL_ACK_BIT = 0;
    localparam int CTRL_SW_ERR_BIT = 1;
    localparam int IRQ_GSHUT_BIT = 0;
    localparam int IRQ_GFAULT_BIT = 1;
    localparam int IRQ_MSHUT_BIT = 2;
    localparam int IRQ_LIMIT_BIT = 3;
    localparam int IRQ_W = 4;

    // ------------------------------------------------------------
    // Reset values and limits
    // ------------------------------------------------------------
    localparam logic [15:0] SAFE_ADDR_RST = 16'h0001;
    localparam int IMG_IN_BYTES = 7;
    localparam int IMG_OUT_BYTES = 7;
    localparam int IMG_USAGE_BYTES = 2;
    localparam int AXIS_A_BYTE = 0;
    localparam int AXIS_B_BYTE = 1;
    localparam int MAX_CONN = 8;
    localparam int MAX_CRC = 12;
    localparam int MAX_SAFE_BYTES = 24;
    localparam int MAX_TELEGRAM_BYTES = 51;
    localparam int SMALL_CONN_BYTES = 2;
    localparam int MAX_STD_IN_BYTES = 54;
    localparam int MAX_STD_OUT_BYTES = 62;
    localparam logic [31:0] SERIAL_DEFAULT = 32'h00001234; // Arbitrary value

    // ------------------------------------------------------------
    // Error states, ranked by severity
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_RUN = 4'b0001,
        ST_MSHUT = 4'b0010,
        ST_GSHUT = 4'b0100,
        ST_GFAULT = 4'b1000
    } sto_state_t;

    typedef struct packed {
        logic transientFault;
        logic integrityFault;
        logic softwareFault;
    } sto_faults_t;

    typedef struct packed {
        logic axisA;
        logic axisB;
    } sto_axes_t;
endpackage : sto_pkg

// [dv/sto_ctrl_model.sv]
`timescale 1ns/1ps
// Safety controller side: builds the input process image
module sto_ctrl_model (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Wanted axis commands, 1 = motion allowed
    input wire logic cmdA,
    input wire logic cmdB,
    // Image towards the device
    output logic [55:0] imageIn
);
    logic [7:0] fill;
    // Filler bits change every cycle
    always_ff @(posedge core_clk) begin
        if (reset) begin
            fill <= 8'h5a;
        end else begin
            fill <= fill + 8'h01;
        end
    end
    // Commands at byte 0 bit 0 and byte 1 bit 0
    assign imageIn = {{5{fill}}, fill[7:1], cmdB, fill[7:1], cmdA};
endmodule : sto_ctrl_model

// [dv/sto_error_supervisor_tb.sv]
`timescale 1ns/1ps
module sto_error_supervisor_tb;
    import sto_pkg::*;
    logic core_clk, reset, hsel, hwrite, cmdA, cmdB, rdPh, irq, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, good, bad;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [55:0] imageIn, imageOut;
    sto_faults_t faultIn;
    sto_axes_t path, fb;
    sto_state_t errorState;
    logic [31:0] expQ[$];
    int miscompares, compares, n, c;
    // ----------------------------------------
    // Design and controller model
    // ----------------------------------------
    sto_error_supervisor dut_u (.core_clk(core_clk), .reset(reset), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .faultIn(faultIn), .imageIn(imageIn), .axisSwitchOffPath(path),
        .driveTorqueOffFeedback(fb), .imageOut(imageOut), .errorState(errorState),
        .irq(irq));
    sto_ctrl_model ctrl_u (.core_clk(core_clk), .reset(reset), .cmdA(cmdA),
        .cmdB(cmdB), .imageIn(imageIn));
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        compares++;
        if (seen !== want) begin
            miscompares++;
            $display("wrong value at %0t: got %h want %h", $time, seen, want);
        end
    endtask : check
    task report_and_stop();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : report_and_stop
    // One AHB-Lite single transfer; reads note the expected word
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= w;
        hsize <= 3'b010;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        if (w) hwdata <= d;
        else expQ.push_back(d);
        do @(posedge core_clk); while (hreadyout !== 1'b1);
    endtask : xfer
    task pins(input logic [1:0] p, input logic [3:0] s, input int wt);
        repeat (wt) @(posedge core_clk);
        check({30'h0, path}, {30'h0, p});
        check({30'h0, fb}, {30'h0, p});
        check(imageOut[31:0], {30'h0, p[0], p[1]});
        check({8'h0, imageOut[55:32]}, 32'h0);
        check({28'h0, errorState}, {28'h0, s});
    endtask : pins
    task doReset();
        reset <= 1'b1;
        repeat (2) @(posedge core_clk);
        reset <= 1'b0;
    endtask : doReset
    // ----------------------------------------
    // Clock, monitor, watchdog
    // ----------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    // Read data is compared in its data phase
    always @(posedge core_clk) begin
        if (rdPh) check(hrdata, expQ.pop_front());
        if (rdPh) check({31'h0, hresp}, 32'h0);
        rdPh <= hsel && htrans[1] && !hwrite;
    end
    initial begin
        #100000;
        miscompares++;
        report_and_stop();
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        {reset, hsel, hwrite, cmdA, cmdB, rdPh} = 6'h20;
        {haddr, hwdata, htrans, hsize, faultIn} = '0;
        void'($urandom(83191));
        doReset();
        xfer(0, OFS_SAFE_ADDR, 32'h1);
        xfer(0, OFS_SERIAL, SERIAL_DEFAULT);
        xfer(0, OFS_STATUS, 32'h1);
        xfer(0, 8'h40, 32'h0);
        xfer(1, OFS_SAFE_ADDR, 32'h0001a5c3);
        xfer(0, OFS_SAFE_ADDR, 32'h0000a5c3);
        pins(2'b00, ST_RUN, 1);
        $display("test reset done");
        {cmdA, cmdB} <= 2'b11;
        pins(2'b11, ST_RUN, 6);
        cmdB <= 1'b0;
        pins(2'b10, ST_RUN, 6);
        xfer(0, OFS_STATUS, 32'h21);
        xfer(0, OFS_IMG_OUT, 32'h1);
        $display("test axes done");
        xfer(1, OFS_IRQ_MASK, 32'hf);
        xfer(1, OFS_CTRL, 32'h2);
        pins(2'b00, ST_MSHUT, 6);
        check({31'h0, irq}, 32'h1);
        xfer(0, OFS_CTRL, 32'h1);
        xfer(0, OFS_IRQ_STAT, 32'h4);
        xfer(1, OFS_IRQ_MASK, 32'h0);
        pins(2'b00, ST_MSHUT, 2);
        check({31'h0, irq}, 32'h0);
        xfer(1, OFS_CTRL, 32'h1);
        xfer(1, OFS_IRQ_STAT, 32'h4);
        xfer(1, OFS_IRQ_MASK, 32'hf);
        pins(2'b10, ST_RUN, 6);
        check({31'h0, irq}, 32'h0);
        faultIn <= 3'b001;
        pins(2'b00, ST_MSHUT, 8);
        check({31'h0, irq}, 32'h1);
        faultIn <= 3'b000;
        pins(2'b00, ST_MSHUT, 3);
        xfer(1, OFS_CTRL, 32'h1);
        xfer(1, OFS_IRQ_STAT, 32'h4);
        pins(2'b10, ST_RUN, 6);
        $display("test module shutdown done");
        for (int r = 0; r < 3; r++) begin
            n = 1 + $urandom % 8;
            c = n + $urandom % (13 - n);
            good = {2'b0, 6'($urandom % 63), 2'b0, 6'($urandom % 55), 3'b0,
                5'($urandom % 25), 4'(c), 4'(n)};
            xfer(1, OFS_CONN, good);
            xfer(0, OFS_CONN, good);
        end
        for (int k = 0; k < 5; k++) begin
            bad = good;
            case (k)
                0: bad[3:0] = 4'h9;
                1: bad[7:4] = 4'hd;
                2: bad[12:8] = 5'd25;
                3: bad[21:16] = 6'd55;
                default: bad[29:24] = 6'd63;
            endcase
            xfer(1, OFS_CONN, bad);
            xfer(0, OFS_CONN, good);
        end
        xfer(0, OFS_IRQ_STAT, 32'h8);
        xfer(1, OFS_IRQ_STAT, 32'h8);
        $display("test limits done");
        faultIn <= 3'b100;
        pins(2'b00, ST_GSHUT, 8);
        check({31'h0, irq}, 32'h1);
        xfer(1, OFS_CTRL, 32'h2);
        pins(2'b00, ST_GSHUT, 6);
        faultIn <= 3'b110;
        pins(2'b00, ST_GFAULT, 8);
        faultIn <= 3'b000;
        xfer(1, OFS_CTRL, 32'h1);
        pins(2'b00, ST_GFAULT, 8);
        doReset();
        pins(2'b10, ST_RUN, 6);
        xfer(0, OFS_SAFE_ADDR, 32'h1);
        $display("test global states done");
        report_and_stop();
    end
endmodule : sto_error_supervisor_tb
